/* File: rtl/csi_pkg.sv */
/*
 * Constants of the clock source interrupt block: register offsets, source bit
 * layout, reset values and bus widths.
 * Assumes a single bus clock and one asynchronous active-high reset.
 */
package csi_pkg;

    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int BE_W    = DATA_W / 8;
    localparam int NUM_SRC = 10;

    localparam logic [ADDR_W-1:0] OFS_ENABLE_SET    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_STATE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PENDING_STATE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PENDING_CLEAR = 8'h10;

    localparam int POS_XTAL_OSC_READY     = 0;
    localparam int POS_FLL_COARSE_LOCKED  = 1;
    localparam int POS_FLL_FINE_LOCKED    = 2;
    localparam int POS_FLL_SYNC_READY     = 3;
    localparam int POS_FLL_REF_STOPPED    = 4;
    localparam int POS_PLL_LOCKED         = 6;
    localparam int POS_PLL_LOCK_LOST      = 7;
    localparam int POS_FAST_RC_LOCKED     = 13;
    localparam int POS_FAST_RC_LOCK_LOST  = 14;
    localparam int POS_TOP_FLAG_BIT31     = 31;

    // Source index to register bit position, in source input order.
    localparam int SRC_POS [NUM_SRC] = '{
        POS_XTAL_OSC_READY, POS_FLL_COARSE_LOCKED, POS_FLL_FINE_LOCKED,
        POS_FLL_SYNC_READY, POS_FLL_REF_STOPPED, POS_PLL_LOCKED,
        POS_PLL_LOCK_LOST, POS_FAST_RC_LOCKED, POS_FAST_RC_LOCK_LOST,
        POS_TOP_FLAG_BIT31
    };

    localparam logic [DATA_W-1:0] RST_ENABLE_STATE  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_PENDING_STATE = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_READDATA      = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_ZERO         = 32'h0000_0000;
    localparam logic [NUM_SRC-1:0] RST_SRC          = 10'h000;

endpackage

/* File: rtl/csi_evt_if.sv */
/*
 * Carries one-cycle source event pulses from the capture stage to the core.
 * Assumes both ends run on the same bus clock.
 */
`timescale 1ns/1ps
interface csi_evt_if
    import csi_pkg::*;
();
    logic [DATA_W-1:0] evt;

    modport capture (output evt);
    modport core    (input  evt);
endinterface

/* File: rtl/csi_event_capture.sv */
/*
 * Synchronises the clock source status levels and turns each rising edge into
 * a one-cycle event on its register bit position.
 * Assumes the levels are asynchronous to mclk and stay high for at least two
 * mclk periods; shorter glitches may be missed.
 */
`timescale 1ns/1ps
module csi_event_capture
    import csi_pkg::*;
#(
    parameter int N_SRC = NUM_SRC
)(
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [N_SRC-1:0] src_level,
    csi_evt_if.capture            evt_bus
);

    logic [N_SRC-1:0] meta;
    logic [N_SRC-1:0] stable;
    logic [N_SRC-1:0] stable_d;
    logic [N_SRC-1:0] rise;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta     <= RST_SRC;
            stable   <= RST_SRC;
            stable_d <= RST_SRC;
        end else begin
            meta     <= src_level;
            stable   <= meta;
            stable_d <= stable;
        end
    end

    // Only the second and third stages feed the edge detector, never the first.
    assign rise = stable & ~stable_d;

    always_comb begin
        evt_bus.evt = READ_ZERO;
        for (int i = 0; i < N_SRC; i++) begin
            evt_bus.evt[SRC_POS[i]] = rise[i];
        end
    end

endmodule

/* File: rtl/csi_irq_top.sv */
/*
 * Interrupt enable, mask and pending registers of the clock source controller,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes a 20 MHz mclk, asynchronous status levels from the oscillators and
 * loops, and a master that holds each request until waitrequest is low.
 */
`timescale 1ns/1ps
module csi_irq_top
    import csi_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [DATA_W-1:0]   avs_writedata,
    input  wire logic [BE_W-1:0]     avs_byteenable,
    output logic      [DATA_W-1:0]   avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic [NUM_SRC-1:0]  src_level,
    output logic                     irq
);

    csi_evt_if evt_link ();

    csi_event_capture #(
        .N_SRC (NUM_SRC)
    ) u_capture (
        .mclk      (mclk),
        .reset     (reset),
        .src_level (src_level),
        .evt_bus   (evt_link)
    );

    logic [DATA_W-1:0] valid_mask;
    logic [DATA_W-1:0] be_mask;
    logic [DATA_W-1:0] wr_bits;
    logic [DATA_W-1:0] enable_state;
    logic [DATA_W-1:0] pending_state;
    logic [DATA_W-1:0] next_enable_state;
    logic [DATA_W-1:0] next_pending_state;
    logic [DATA_W-1:0] next_readdata;
    logic              next_waitrequest;
    logic              next_irq;
    wire               request;
    wire               commit;
    wire               wr_commit;
    wire               hit_enable_set;
    wire               hit_enable_clear;
    wire               hit_enable_state;
    wire               hit_pending_state;
    wire               hit_pending_clear;
    wire [DATA_W-1:0]  set_mask_bits;
    wire [DATA_W-1:0]  clr_mask_bits;
    wire [DATA_W-1:0]  clr_pend_bits;

    // Bits that exist in every register; everything else is reserved.
    always_comb begin
        valid_mask = READ_ZERO;
        for (int i = 0; i < NUM_SRC; i++) begin
            valid_mask[SRC_POS[i]] = 1'b1;
        end
    end

    genvar b;
    generate
        for (b = 0; b < BE_W; b++) begin : g_be
            assign be_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
        end
    endgenerate

    // One wait state: the first cycle of a request is held, the second answers.
    // Read data is latched in the held cycle, so it is stable while answered.
    assign request   = avs_read | avs_write;
    assign commit    = request & ~avs_waitrequest;
    assign wr_commit = avs_write & ~avs_waitrequest;
    assign wr_bits   = avs_writedata & be_mask & valid_mask;

    assign hit_enable_set    = (avs_address == OFS_ENABLE_SET);
    assign hit_enable_clear  = (avs_address == OFS_ENABLE_CLEAR);
    assign hit_enable_state  = (avs_address == OFS_ENABLE_STATE);
    assign hit_pending_state = (avs_address == OFS_PENDING_STATE);
    assign hit_pending_clear = (avs_address == OFS_PENDING_CLEAR);

    // Zero bits give zero terms, so they leave the state alone.
    assign set_mask_bits = wr_commit & hit_enable_set    ? wr_bits : READ_ZERO;
    assign clr_mask_bits = wr_commit & hit_enable_clear  ? wr_bits : READ_ZERO;
    assign clr_pend_bits = wr_commit & hit_pending_clear ? wr_bits : READ_ZERO;

    // Disable wins if software sets and clears the same bit, which it cannot
    // do in one access anyway.
    assign next_enable_state = (enable_state | set_mask_bits) & ~clr_mask_bits;

    // An event in the cycle of its clear survives: set wins over clear.
    assign next_pending_state = (pending_state & ~clr_pend_bits)
                              | (evt_link.evt & valid_mask);

    assign next_irq = |(next_pending_state & next_enable_state);

    assign next_waitrequest = ~(request & avs_waitrequest);

    // Write-only and unmapped offsets read as zero.
    assign next_readdata = ~avs_read          ? avs_readdata :
                           hit_enable_state   ? enable_state & valid_mask :
                           hit_pending_state  ? pending_state & valid_mask :
                           READ_ZERO;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            enable_state  <= RST_ENABLE_STATE;
            pending_state <= RST_PENDING_STATE;
            irq           <= 1'b0;
        end else begin
            enable_state  <= next_enable_state;
            pending_state <= next_pending_state;
            irq           <= next_irq;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= RST_READDATA;
        end else begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= commit ? avs_readdata : next_readdata;
        end
    end

endmodule

/* File: verif/csi_irq_sva.sv */
/* Port checker for csi_irq_top.
   Assumes one mclk domain and is bound onto the top module. */
`timescale 1ns/1ps
module csi_irq_sva
    import csi_pkg::*;
(
    input wire logic                mclk,
    input wire logic                reset,
    input wire logic [ADDR_W-1:0]   avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [DATA_W-1:0]   avs_writedata,
    input wire logic [BE_W-1:0]     avs_byteenable,
    input wire logic [DATA_W-1:0]   avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic [NUM_SRC-1:0]  src_level,
    input wire logic                irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence taken_s; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence done_s; avs_write && !avs_waitrequest; endsequence
    sequence all_off_s; done_s ##0 (avs_address == 8'h04 && avs_writedata == 32'hFFFF_FFFF
        && avs_byteenable == 4'hF); endsequence
    wire logic wr_done = avs_write && !avs_waitrequest;
    answer_next_a: assert property (taken_s |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    idle_wait_a: assert property (
        !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    all_off_a: assert property (all_off_s |=> !irq)
        else $error("irq stays high with all sources disabled");
    wo_zero_a: assert property (
        avs_read && avs_waitrequest && avs_address == 8'h00 |=> avs_readdata == 32'h0000_0000)
        else $error("write-only register reads nonzero");
    irq_fall_a: assert property ($fell(irq) |-> $past(wr_done))
        else $error("irq fell without a write");
    irq_rise_a: assert property (
        $rose(irq) |-> $past(wr_done) || $past(src_level, 2) != $past(src_level, 6))
        else $error("irq rose without cause");
    reserved_a: assert property (
        !avs_waitrequest |-> (avs_readdata & ~32'h8000_60DF) == 32'h0000_0000)
        else $error("reserved bit reads one");
endmodule
bind csi_irq_top csi_irq_sva u_sva (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_level(src_level), .irq(irq));

/* File: verif/clock_source_interrupt_regs_tb_top.sv */
/* Self-checking bench for csi_irq_top.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module clock_source_interrupt_regs_tb_top
    import csi_pkg::*;
;
    logic                mclk = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
    logic [ADDR_W-1:0]   avs_address = '0;
    logic [DATA_W-1:0]   avs_writedata = '0, avs_readdata, q;
    logic [BE_W-1:0]     avs_byteenable = '1;
    logic [NUM_SRC-1:0]  src_level = '0;
    int                  mismatches = 0, checks = 0;
    // Each row: write flag, address, then write data or expected read data.
    logic [40:0]         rows [10] = '{{1'b0, 8'h08, 32'h0}, {1'b0, 8'h0C, 32'h0},
        {1'b1, 8'h00, 32'hFFFF_FFFF}, {1'b0, 8'h08, 32'h8000_60DF}, {1'b1, 8'h04, 32'h0000_00C0},
        {1'b0, 8'h08, 32'h8000_601F}, {1'b0, 8'h00, 32'h0}, {1'b0, 8'h14, 32'h0},
        {1'b1, 8'h08, 32'hFFFF_FFFF}, {1'b0, 8'h08, 32'h8000_601F}};
    csi_irq_top DUT (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .src_level(src_level), .irq(irq));
    initial forever #25 mclk = ~mclk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    // Waitrequest and read data are taken at the rising edge, before the design updates them.
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [BE_W-1:0] be);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (avs_waitrequest !== 1'b0) begin
            mismatches++;
            conclude();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        chk("reset readdata", RST_READDATA, avs_readdata);
        chk("reset waitrequest", 32'h1, {31'h0, avs_waitrequest});
        chk("reset irq", 32'h0, {31'h0, irq});
        reset <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            bus(rows[i][40], rows[i][39:32], rows[i][31:0], 4'hF);
            if (!rows[i][40]) chk("row", rows[i][31:0], q);
        end
        src_level <= 10'h3FF;
        repeat (8) @(posedge mclk);
        bus(0, 8'h0C, 0, 4'hF);
        chk("pend", 32'h8000_60DF, q);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1, 8'h10, 32'hFFFF_FFFF, 4'h1);
        bus(0, 8'h0C, 0, 4'hF);
        chk("pend", 32'h8000_6000, q);
        bus(1, 8'h04, 32'hFFFF_FFFF, 4'hF);
        @(negedge mclk);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1, 8'h10, 32'hFFFF_FFFF, 4'hF);
        bus(0, 8'h0C, 0, 4'hF);
        chk("pend", 32'h0, q);
        src_level <= 10'h000;
        repeat (4) @(posedge mclk);
        src_level <= 10'h001;
        repeat (8) @(posedge mclk);
        bus(0, 8'h0C, 0, 4'hF);
        chk("pend", 32'h1, q);
        chk("irq", 32'h0, {31'h0, irq});
        // The clear commits on the same edge as the new event of bit 1: the event must survive.
        src_level <= 10'h003;
        bus(1, 8'h10, 32'h0000_0003, 4'hF);
        bus(0, 8'h0C, 0, 4'hF);
        chk("pend", 32'h0000_0002, q);
        bus(1, 8'h00, 32'h0000_0002, 4'hF);
        @(negedge mclk);
        chk("irq", 32'h1, {31'h0, irq});
        @(posedge mclk);
        src_level <= 10'h000;
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        chk("reset irq", 32'h0, {31'h0, irq});
        bus(0, 8'h0C, 0, 4'hF);
        chk("pend", 32'h0, q);
        bus(0, 8'h08, 0, 4'hF);
        chk("mask", 32'h0, q);
        conclude();
    end
endmodule
